//--- verilog/buerr_pkg.sv
// Shared constants for the bus unit error capture block.
package buerr_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] BUERR_OFF_CTRL   = 8'h00;  // Load/store unit control enables.
	localparam logic [7:0] BUERR_OFF_HW_INTERRUPT_ENABLE_REG   = 8'h04;  // Hardware interrupt enable.
	localparam logic [7:0] BUERR_OFF_STAT   = 8'h08;  // Error status.
	localparam logic [7:0] BUERR_OFF_BADDR  = 8'h0c;  // Bus error address.
	localparam logic [7:0] BUERR_OFF_FADDR  = 8'h10;  // Fill error address.
	localparam logic [7:0] BUERR_OFF_SYND   = 8'h14;  // Fill error syndrome.
	localparam logic [7:0] BUERR_OFF_TAG    = 8'h18;  // External cache tag capture.
	localparam logic [7:0] BUERR_OFF_LOCK   = 8'h1c;  // Lock state, write one to unlock.
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BUERR_CTRL_CORRECTED_REPORT_ENABLE  = 0;  // Corrected report enable.
	localparam int BUERR_CTRL_UNCORRECTABLE_TRAP_ENABLE = 1;  // Uncorrectable trap enable.
	localparam int BUERR_CTRL_PARITY  = 2;  // Fill checking in parity mode.
	localparam int BUERR_HW_INTERRUPT_ENABLE_REG_CRE     = 0;  // Corrected interrupt mask bit.
	localparam int BUERR_ST_TPERR     = 0;  // Tag address parity flag.
	localparam int BUERR_ST_TCPERR    = 1;  // Tag control parity flag.
	localparam int BUERR_ST_SERR      = 2;  // Soft acknowledge error flag.
	localparam int BUERR_ST_HERR      = 3;  // Hard acknowledge error flag.
	localparam int BUERR_ST_CMD       = 4;  // Failed request command, three bits.
	localparam int BUERR_ST_FATAL_B   = 7;  // Lost bus error flag.
	localparam int BUERR_ST_FECC      = 8;  // Fill ECC flag.
	localparam int BUERR_ST_FDPERR    = 9;  // Fill data error flag.
	localparam int BUERR_ST_FIRD      = 10; // Fill instruction read flag.
	localparam int BUERR_ST_FCRD      = 11; // Fill corrected flag.
	localparam int BUERR_ST_QW        = 12; // Failing quadword index, two bits.
	localparam int BUERR_ST_FATAL_F   = 14; // Lost fill error flag.
	localparam int BUERR_LK_BUS       = 0;  // Bus error set locked.
	localparam int BUERR_LK_FILL      = 1;  // Fill error set locked.
	localparam int BUERR_LK_CRD       = 2;  // Corrected interrupt pending.
	// ------------------------------------------------------------
	// Reset values and trap vectors
	// ------------------------------------------------------------
	localparam logic [2:0]  BUERR_CTRL_RST  = 3'h0;
	localparam logic [11:0] BUERR_VEC_PROC  = 12'h670; // Processor machine check.
	localparam logic [11:0] BUERR_VEC_SYS   = 12'h660; // System machine check.
	localparam logic [11:0] BUERR_VEC_CORR  = 12'h630; // Processor correctable check.
endpackage

//--- verilog/buerr_reg_if.sv
// Register access carrier between the bus slave and the error core.
`timescale 1ns/1ns
`default_nettype none
interface buerr_reg_if;
	logic        wr_en;  // One-cycle write strobe.
	logic [7:0]  addr;   // Byte address of the access.
	logic [31:0] wdata;  // Write data.
	logic [31:0] rdata;  // Read data for addr.
	modport slave (output wr_en, output addr, output wdata, input rdata);
	modport core  (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- verilog/buerr_ahb_slave.sv
// AHB-Lite slave front end for the bus unit error capture block.
`timescale 1ns/1ns
`default_nettype none
module buerr_ahb_slave
	import buerr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	buerr_reg_if.slave       regs
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic        wr_pend;  // Write data phase in progress.
		logic        rd_busy;  // First read data cycle, wait state.
		logic [7:0]  addr;     // Captured byte address.
		logic [31:0] hrdata;   // Registered read data.
	} buerr_slv_t;

	buerr_slv_t st_reg;  // Current state.
	buerr_slv_t st_next; // Next state.
	logic       accept;  // Address phase taken this edge.

	// Reads take one wait state so that hrdata comes from a flop.
	always_comb begin
		st_next = st_reg;
		accept = hsel && htrans[1] && hready && (hsize == 3'h2);
		st_next.wr_pend = 1'b0;
		st_next.rd_busy = 1'b0;
		if (st_reg.rd_busy) begin
			st_next.hrdata = regs.rdata;
		end
		if (accept) begin
			st_next.addr = {haddr[7:2], 2'h0};
			st_next.wr_pend = hwrite;
			st_next.rd_busy = !hwrite;
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hreadyout   = !st_reg.rd_busy;
	assign hrdata      = st_reg.hrdata;
	assign hresp       = 1'b0;  // Always OKAY; unmapped reads give zero.
	assign regs.wr_en  = st_reg.wr_pend;
	assign regs.addr   = st_reg.addr;
	assign regs.wdata  = hwdata;
endmodule
`default_nettype wire

//--- verilog/buerr_top.sv
// Bus unit error capture core with its register file.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Corrected errors interrupt only when report enabled.
// - Interrupt enable mask bit holds pending request.
// - No corrected interrupt in privileged firmware mode.
// - Uncorrected errors trap only when trap enabled.
// - Vectors 670, 660 and 630 hex.
// - Single-bit instruction fill: ECC, read, corrected set.
// - Single-bit data fill: ECC, corrected set.
// - Double-bit instruction fill: data error, read set.
// - Double-bit data fill: data error only.
// - Fill address 33:5 and quadword index captured.
// - Data fills also capture address bits 4:2.
// - Single-bit fills record the ECC syndrome.
// - Fill error locks bus address and status.
// - Tag probe kept when external cache enabled and bus set not already locked.
// - Tag address parity: miss, capture, flag, trap.
// - Tag control parity: miss, capture, flag, trap.
// - Soft acknowledge: interrupt, flag, command, address.
// - Hard acknowledge: trap, flag, command, address.
// - Parity instruction fill: data error, read set.
// - Parity data fill: cache validated, data error.
// - Captured set stays locked until firmware unlocks.
// - Lost flag on fatal error while locked.
module buerr_top
	import buerr_pkg::*;
#(
	parameter int         TAG_W     = 24,    // External cache tag probe width.
	parameter int         SYND_W    = 16,    // Fill syndrome width.
	parameter logic [2:0] SOFT_CODE = 3'h2,  // Soft error acknowledge code.
	parameter logic [2:0] HARD_CODE = 3'h3   // Hard error acknowledge code.
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	input  wire logic              privileged_firmware_mode,
	input  wire logic              fill_err_valid,
	input  wire logic              fill_single_bit,
	input  wire logic              fill_istream,
	input  wire logic [33:2]       fill_pa,
	input  wire logic [1:0]        failing_quadword_index,
	input  wire logic [SYND_W-1:0] fill_syndrome,
	input  wire logic              ext_cache_enabled,
	input  wire logic [TAG_W-1:0]  tag_probe_result,
	input  wire logic              probe_done,
	input  wire logic              tag_addr_perr,
	input  wire logic              tag_ctrl_perr,
	input  wire logic [33:2]       probe_addr,
	input  wire logic              ack_valid,
	input  wire logic [2:0]        command_acknowledge_lines,
	input  wire logic [2:0]        command_request_lines,
	input  wire logic [33:2]       request_addr,
	output logic                   corrected_read_irq,
	output logic                   machine_check,
	output logic [11:0]            trap_vector,
	output logic                   icache_load_validate,
	output logic                   regfile_write,
	output logic                   dcache_invalidate,
	output logic                   dcache_load_validate,
	output logic                   probe_force_miss
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]        ctrl;       // Report, trap and parity mode enables.
		logic              hw_interrupt_enable_reg_cre;   // Corrected interrupt mask bit.
		logic              crd_pend;   // Pending corrected-read request.
		logic              bus_lock;   // Bus error set locked.
		logic              fill_lock;  // Fill error set locked.
		logic [14:0]       status;     // Error status flags.
		logic [31:0]       baddr;      // Bus error address, bits 33:2.
		logic [31:0]       faddr;      // Fill error address, bits 33:2.
		logic [SYND_W-1:0] synd;       // Fill syndrome.
		logic [TAG_W-1:0]  tag;        // Tag probe capture.
		logic              mchk;       // Machine check pulse.
		logic [11:0]       vec;        // Vector of the last machine check.
		logic [4:0]        act;        // Fill and probe action pulses.
	} buerr_st_t;

	buerr_st_t   st_reg;  // Current state.
	buerr_st_t   st_next; // Next state.
	buerr_reg_if rif ();  // Register access from the bus slave.

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	buerr_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.regs      (rif.slave)
	);

	// Word write decode used by every writable register.
	function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
		wr_hit = en && (a == off);
	endfunction

	// ------------------------------------------------------------
	// Event decode
	// ------------------------------------------------------------
	logic        tag_err;     // Tag parity error at end of probe.
	logic        soft_ack;    // Soft error acknowledge returned.
	logic        hard_ack;    // Hard error acknowledge returned.
	logic        bus_evt;     // Any event for the bus error set.
	logic        fill_ecc1;   // Single-bit ECC fill, not parity mode.
	logic        fill_unc;    // Uncorrected fill error.
	logic        unlk_bus;    // Firmware unlocks the bus set.
	logic        unlk_fill;   // Firmware unlocks the fill set.
	logic        clr_crd;     // Firmware clears the pending request.
	logic        lk_wr;       // Write to the lock register.

	assign tag_err   = probe_done && (tag_addr_perr || tag_ctrl_perr);
	assign soft_ack  = ack_valid && (command_acknowledge_lines == SOFT_CODE);
	assign hard_ack  = ack_valid && (command_acknowledge_lines == HARD_CODE);
	assign bus_evt   = tag_err || soft_ack || hard_ack;
	assign fill_ecc1 = fill_err_valid && fill_single_bit && !st_reg.ctrl[BUERR_CTRL_PARITY];
	assign fill_unc  = fill_err_valid && !fill_ecc1;
	assign lk_wr     = wr_hit(rif.wr_en, rif.addr, BUERR_OFF_LOCK);
	assign unlk_bus  = lk_wr && rif.wdata[BUERR_LK_BUS];
	assign unlk_fill = lk_wr && rif.wdata[BUERR_LK_FILL];
	assign clr_crd   = lk_wr && rif.wdata[BUERR_LK_CRD];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Unlocks and clears are applied first, so that an error in the same
	// cycle is captured and its flag wins over the clear.
	always_comb begin
		st_next = st_reg;
		st_next.mchk = 1'b0;
		st_next.act = '0;
		// Software register writes.
		if (wr_hit(rif.wr_en, rif.addr, BUERR_OFF_CTRL)) begin
			st_next.ctrl = rif.wdata[2:0];
		end
		if (wr_hit(rif.wr_en, rif.addr, BUERR_OFF_HW_INTERRUPT_ENABLE_REG)) begin
			st_next.hw_interrupt_enable_reg_cre = rif.wdata[BUERR_HW_INTERRUPT_ENABLE_REG_CRE];
		end
		if (unlk_bus) begin
			st_next.bus_lock = 1'b0;
			st_next.status[BUERR_ST_FATAL_B] = 1'b0;
		end
		if (unlk_fill) begin
			st_next.fill_lock = 1'b0;
			st_next.status[BUERR_ST_FATAL_F] = 1'b0;
		end
		if (clr_crd) begin
			st_next.crd_pend = 1'b0;
		end
		// Bus error set: tag probe parity and acknowledge errors.
		if (bus_evt) begin
			if (!st_next.bus_lock) begin
				st_next.bus_lock = 1'b1;
				st_next.status[7:0] = '0;
				st_next.status[BUERR_ST_TPERR] = tag_err && tag_addr_perr;
				st_next.status[BUERR_ST_TCPERR] = tag_err && tag_ctrl_perr;
				st_next.status[BUERR_ST_SERR] = soft_ack;
				st_next.status[BUERR_ST_HERR] = hard_ack;
				if (tag_err) begin
					st_next.baddr = probe_addr;
					st_next.tag = tag_probe_result;
				end else begin
					st_next.baddr = request_addr;
					st_next.status[BUERR_ST_CMD +: 3] = command_request_lines;
				end
			end else if (tag_err || hard_ack) begin
				// A soft acknowledge loses nothing fatal.
				st_next.status[BUERR_ST_FATAL_B] = 1'b1;
			end
		end
		// Fill error set.
		if (fill_err_valid) begin
			if (!st_next.fill_lock) begin
				st_next.fill_lock = 1'b1;
				st_next.bus_lock = 1'b1;
				st_next.status[BUERR_ST_FECC] = fill_ecc1;
				st_next.status[BUERR_ST_FDPERR] = fill_unc;
				st_next.status[BUERR_ST_FIRD] = fill_istream;
				st_next.status[BUERR_ST_FCRD] = fill_ecc1;
				st_next.status[BUERR_ST_QW +: 2] = failing_quadword_index;
				st_next.faddr = {fill_pa[33:5], 3'h0};
				if (!fill_istream) begin
					st_next.faddr[2:0] = fill_pa[4:2];
				end
				st_next.synd = fill_syndrome;
				if (ext_cache_enabled && !st_reg.bus_lock) begin
					st_next.tag = tag_probe_result;
				end
			end else begin
				st_next.status[BUERR_ST_FATAL_F] = 1'b1;
			end
			// Where the corrupted block goes.
			if (fill_istream) begin
				st_next.act[0] = 1'b1;
			end else if (st_reg.ctrl[BUERR_CTRL_PARITY]) begin
				st_next.act[3] = 1'b1;
			end else begin
				st_next.act[1] = 1'b1;
				st_next.act[2] = 1'b1;
			end
		end
		if (tag_err) begin
			st_next.act[4] = 1'b1;
		end
		// Corrected errors post a request, even with the sets locked.
		if ((fill_ecc1 || soft_ack) && st_reg.ctrl[BUERR_CTRL_CORRECTED_REPORT_ENABLE]) begin
			st_next.crd_pend = 1'b1;
		end
		// Machine check, system errors first.
		if (st_reg.ctrl[BUERR_CTRL_UNCORRECTABLE_TRAP_ENABLE]) begin
			if (hard_ack) begin
				st_next.mchk = 1'b1;
				st_next.vec = BUERR_VEC_SYS;
			end else if (tag_err || fill_unc) begin
				st_next.mchk = 1'b1;
				st_next.vec = BUERR_VEC_PROC;
			end else if (fill_ecc1) begin
				st_next.mchk = 1'b1;
				st_next.vec = BUERR_VEC_CORR;
			end
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.ctrl <= BUERR_CTRL_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	// Unmapped offsets read as zero.
	always_comb begin
		rif.rdata = '0;
		case (rif.addr)
			BUERR_OFF_CTRL:  rif.rdata[2:0] = st_reg.ctrl;
			BUERR_OFF_HW_INTERRUPT_ENABLE_REG:  rif.rdata[BUERR_HW_INTERRUPT_ENABLE_REG_CRE] = st_reg.hw_interrupt_enable_reg_cre;
			BUERR_OFF_STAT:  rif.rdata[14:0] = st_reg.status;
			BUERR_OFF_BADDR: rif.rdata = st_reg.baddr;
			BUERR_OFF_FADDR: rif.rdata = st_reg.faddr;
			BUERR_OFF_SYND:  rif.rdata[SYND_W-1:0] = st_reg.synd;
			BUERR_OFF_TAG:   rif.rdata[TAG_W-1:0] = st_reg.tag;
			BUERR_OFF_LOCK:  rif.rdata[2:0] = {st_reg.crd_pend, st_reg.fill_lock, st_reg.bus_lock};
			default:         rif.rdata = '0;
		endcase
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign corrected_read_irq   = st_reg.crd_pend && st_reg.hw_interrupt_enable_reg_cre
	                              && !privileged_firmware_mode;
	assign machine_check        = st_reg.mchk;
	assign trap_vector          = st_reg.vec;
	assign icache_load_validate = st_reg.act[0];
	assign regfile_write        = st_reg.act[1];
	assign dcache_invalidate    = st_reg.act[2];
	assign dcache_load_validate = st_reg.act[3];
	assign probe_force_miss     = st_reg.act[4];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_hard_enabled;
		hard_ack && st_reg.ctrl[BUERR_CTRL_UNCORRECTABLE_TRAP_ENABLE];
	endsequence
	sequence s_sys_trap;
		machine_check && (trap_vector == 12'h660);
	endsequence

	property p_crd_gate;
		corrected_read_irq |-> st_reg.hw_interrupt_enable_reg_cre && !privileged_firmware_mode;
	endproperty
	a_crd_gate: assert property (p_crd_gate) else $error("irq passed mask");

	property p_crd_set;
		(soft_ack && st_reg.ctrl[BUERR_CTRL_CORRECTED_REPORT_ENABLE]) |=> st_reg.crd_pend;
	endproperty
	a_crd_set: assert property (p_crd_set) else $error("soft ack no request");

	property p_no_crd;
		(!st_reg.ctrl[BUERR_CTRL_CORRECTED_REPORT_ENABLE] && !st_reg.crd_pend) |=> !st_reg.crd_pend;
	endproperty
	a_no_crd: assert property (p_no_crd) else $error("request while disabled");

	property p_sys_vec;
		s_hard_enabled |=> s_sys_trap;
	endproperty
	a_sys_vec: assert property (p_sys_vec) else $error("hard ack vector wrong");

	property p_no_trap;
		!st_reg.ctrl[BUERR_CTRL_UNCORRECTABLE_TRAP_ENABLE] |=> !machine_check;
	endproperty
	a_no_trap: assert property (p_no_trap) else $error("trap while disabled");

	property p_fill_instr_read_flag;
		(fill_err_valid && !st_reg.fill_lock) |=>
			st_reg.fill_lock && (st_reg.status[BUERR_ST_FIRD] == $past(fill_istream));
	endproperty
	a_fill_instr_read_flag: assert property (p_fill_instr_read_flag) else $error("fill read flag wrong");

	property p_locked_hold;
		(st_reg.bus_lock && !unlk_bus) |=> $stable(st_reg.baddr);
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("locked address changed");

	property p_fatal_bus;
		(st_reg.bus_lock && !unlk_bus && (tag_err || hard_ack)) |=> st_reg.status[BUERR_ST_FATAL_B];
	endproperty
	a_fatal_bus: assert property (p_fatal_bus) else $error("lost bus flag missing");

	property p_miss;
		(tag_err |=> probe_force_miss) and (!tag_err |=> !probe_force_miss);
	endproperty
	a_miss: assert property (p_miss) else $error("probe miss not forced");

	property p_fill_lock_bus;
		(fill_err_valid && !st_reg.fill_lock) |=> st_reg.bus_lock;
	endproperty
	a_fill_lock_bus: assert property (p_fill_lock_bus) else $error("bus set not locked");
endmodule
`default_nettype wire

//--- verif/buerr_far_model.sv
// Behavioural model of the bus interface controller and external cache event lines.
`timescale 1ns/1ns
`default_nettype none
module buerr_far_model #(
	parameter logic [2:0] SOFT = 3'h2,  // Soft error acknowledge code.
	parameter logic [2:0] HARD = 3'h3   // Hard error acknowledge code.
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       go,
	input  wire logic [2:0] kind,
	output logic            fill_err_valid,
	output logic            probe_done,
	output logic            tag_addr_perr,
	output logic            tag_ctrl_perr,
	output logic            ack_valid,
	output logic [2:0]      ack_code
);
	// Each request becomes a one-cycle pulse; kinds 0 fill, 1 tag address, 2 tag control, 4 soft, 5 hard.
	// Idle acknowledge lines invert their previous value every cycle, so nothing rides on a stale value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{fill_err_valid, probe_done, tag_addr_perr, tag_ctrl_perr, ack_valid} <= 5'h00;
			ack_code <= 3'h0;
		end else begin
			fill_err_valid <= go && kind == 3'h0;
			probe_done     <= go && (kind == 3'h1 || kind == 3'h2);
			tag_addr_perr  <= go && kind == 3'h1;
			tag_ctrl_perr  <= go && kind == 3'h2;
			ack_valid      <= go && kind[2];
			ack_code       <= (go && kind[2]) ? (kind[0] ? HARD : SOFT) : ~ack_code;
		end
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the bus unit error capture block.
`timescale 1ns/1ns
`default_nettype none
module tb
	import buerr_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [31:0] F = 32'hffffffff;  // Compare every bit.
	logic hclk, hresetn, hwrite, privileged_firmware_mode, fill_single_bit, fill_istream, ext_cache_enabled, go;
	logic [1:0] htrans, failing_quadword_index;
	logic [2:0] kind, command_acknowledge_lines;
	logic [31:0] haddr, hwdata, hrdata;
	logic [33:2] fill_pa, probe_addr, request_addr;
	logic [15:0] fill_syndrome;
	logic [23:0] tag_probe_result;
	logic [11:0] trap_vector;
	logic hreadyout, hresp, fill_err_valid, probe_done, tag_addr_perr, tag_ctrl_perr, ack_valid;
	logic corrected_read_irq, machine_check, icache_load_validate, regfile_write;
	logic dcache_invalidate, dcache_load_validate, probe_force_miss;
	int n_fail, comparisons;
	// One slave only, so its hreadyout is the bus hready.
	buerr_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .privileged_firmware_mode, .fill_err_valid,
		.fill_single_bit, .fill_istream, .fill_pa, .failing_quadword_index, .fill_syndrome, .ext_cache_enabled,
		.tag_probe_result, .probe_done, .tag_addr_perr, .tag_ctrl_perr, .probe_addr, .ack_valid,
		.command_acknowledge_lines, .command_request_lines(3'h5), .request_addr, .corrected_read_irq,
		.machine_check, .trap_vector, .icache_load_validate, .regfile_write, .dcache_invalidate,
		.dcache_load_validate, .probe_force_miss);
	buerr_far_model far (.hclk, .hresetn, .go, .kind, .fill_err_valid, .probe_done, .tag_addr_perr,
		.tag_ctrl_perr, .ack_valid, .ack_code(command_acknowledge_lines));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task tally_and_finish;
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Waits for hready at a rising edge; a bus that never answers ends the run.
	task wt;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wt;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		r = hrdata;
	endtask
	task rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(n, e, r & m);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		#1;
	endtask
	// Fires one far-side event; outputs are looked at just after the edge at which the core takes it.
	task ev(input logic [2:0] k, input logic sb, input logic is);
		@(posedge hclk);
		go <= 1'b1;
		kind <= k;
		fill_single_bit <= sb;
		fill_istream <= is;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		#1;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_ifill;
		ev(3'h0, 1'b1, 1'b1);
		chk("ival", 1, icache_load_validate);
		chk("vec", BUERR_VEC_CORR, trap_vector);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h3d00);
		rd("faddr", BUERR_OFF_FADDR, F, 32'h12345670);
		rd("synd", BUERR_OFF_SYND, F, 32'h5a5a);
		rd("tag", BUERR_OFF_TAG, F, 32'habcdef);
		rd("lock", BUERR_OFF_LOCK, 32'h3, 32'h3);
		wr(BUERR_OFF_LOCK, 32'h7);
	endtask
	// A second fill while locked is lost: contents stay, the lost flag rises.
	task t_dfill;
		ev(3'h0, 1'b1, 1'b0);
		chk("rfw", 1, regfile_write);
		chk("dinv", 1, dcache_invalidate);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h3900);
		rd("faddr", BUERR_OFF_FADDR, F, 32'h12345675);
		@(posedge hclk) fill_pa <= 32'h0;
		ev(3'h0, 1'b0, 1'b0);
		chk("rfw", 1, regfile_write);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h7900);
		rd("faddr", BUERR_OFF_FADDR, F, 32'h12345675);
		wr(BUERR_OFF_LOCK, 32'h7);
		wr(BUERR_OFF_CTRL, 32'h7);
		@(posedge hclk) {ext_cache_enabled, tag_probe_result} <= 25'h0123456;
		ev(3'h0, 1'b1, 1'b0);
		chk("dval", 1, dcache_load_validate);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h3200);
		rd("tag", BUERR_OFF_TAG, F, 32'habcdef);
		wr(BUERR_OFF_LOCK, 32'h7);
		ev(3'h0, 1'b0, 1'b1);
		chk("ival", 1, icache_load_validate);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h3600);
		wr(BUERR_OFF_LOCK, 32'h7);
		wr(BUERR_OFF_CTRL, 32'h3);
		ev(3'h0, 1'b0, 1'b1);
		rd("stat", BUERR_OFF_STAT, 32'h7f00, 32'h3600);
		wr(BUERR_OFF_LOCK, 32'h7);
	endtask
	task t_tag;
		ev(3'h1, 1'b0, 1'b0);
		chk("miss", 1, probe_force_miss);
		chk("mchk", 1, machine_check);
		chk("vec", BUERR_VEC_PROC, trap_vector);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'h01);
		rd("baddr", BUERR_OFF_BADDR, F, 32'h0fedcba9);
		rd("tag", BUERR_OFF_TAG, F, 32'h123456);
		wr(BUERR_OFF_LOCK, 32'h7);
		ev(3'h2, 1'b0, 1'b0);
		chk("miss", 1, probe_force_miss);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'h02);
		wr(BUERR_OFF_LOCK, 32'h7);
	endtask
	task t_hard;
		ev(3'h5, 1'b0, 1'b0);
		chk("mchk", 1, machine_check);
		chk("vec", BUERR_VEC_SYS, trap_vector);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'h58);
		rd("baddr", BUERR_OFF_BADDR, F, 32'h0abcdef1);
		@(posedge hclk) request_addr <= 32'h11;
		ev(3'h5, 1'b0, 1'b0);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'hd8);
		rd("baddr", BUERR_OFF_BADDR, F, 32'h0abcdef1);
		wr(BUERR_OFF_LOCK, 32'h7);
		wr(BUERR_OFF_CTRL, 32'h1);
		ev(3'h5, 1'b0, 1'b0);
		chk("mchk", 0, machine_check);
		wr(BUERR_OFF_LOCK, 32'h7);
		wr(BUERR_OFF_CTRL, 32'h3);
	endtask
	// The corrected request is masked by firmware mode, the enable mask, and cleared by software.
	task t_soft;
		ev(3'h4, 1'b0, 1'b0);
		chk("irq", 1, corrected_read_irq);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'h54);
		@(posedge hclk) privileged_firmware_mode <= 1'b1;
		#1 chk("irq", 0, corrected_read_irq);
		@(posedge hclk) privileged_firmware_mode <= 1'b0;
		wr(BUERR_OFF_HW_INTERRUPT_ENABLE_REG, 32'h0);
		chk("irq", 0, corrected_read_irq);
		wr(BUERR_OFF_HW_INTERRUPT_ENABLE_REG, 32'h1);
		chk("irq", 1, corrected_read_irq);
		ev(3'h4, 1'b0, 1'b0);
		rd("stat", BUERR_OFF_STAT, 32'hff, 32'h54);
		wr(BUERR_OFF_LOCK, 32'h7);
		wr(BUERR_OFF_CTRL, 32'h2);
		ev(3'h4, 1'b0, 1'b0);
		chk("irq", 0, corrected_read_irq);
	endtask
	// ------------------------------------------------------------
	// Clock, reset and main sequence
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		{hresetn, hwrite, privileged_firmware_mode, fill_single_bit, fill_istream, go} = 6'h00;
		{htrans, kind, haddr, hwdata} = '0;
		ext_cache_enabled = 1'b1;
		fill_pa = 32'h12345675;
		failing_quadword_index = 2'h3;
		fill_syndrome = 16'h5a5a;
		tag_probe_result = 24'habcdef;
		probe_addr = 32'h0fedcba9;
		request_addr = 32'h0abcdef1;
		n_fail = 0;
		comparisons = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd("ctrl", BUERR_OFF_CTRL, F, 32'h0);
		rd("lock", BUERR_OFF_LOCK, F, 32'h0);
		rd("hole", 8'h20, F, 32'h0);
		chk("hresp", 0, hresp);
		wr(BUERR_OFF_CTRL, 32'h3);
		wr(BUERR_OFF_HW_INTERRUPT_ENABLE_REG, 32'h1);
		t_ifill;
		t_dfill;
		t_tag;
		t_hard;
		t_soft;
		tally_and_finish;
	end
endmodule
`default_nettype wire
